// ---- logic/hidden_rtc.sv ----
// Hidden real-time clock behind an asynchronous SRAM bus
//
// Overview of operation
// - Power fail blocks clock and memory access
// - Unlock needs 64 key bits, one per write
// - Before unlock every cycle goes to memory
// - After unlock 64 cycles bypass memory
// - A read restarts key search at bit 0
// - Key writes any address, also store memory
// - Matching bit advances pointer by one
// - Mismatch freezes pointer, ignores later writes
// - Read during search aborts and resets pointer
// - Transfer write takes bit, read drives it
// - Unselected cycles leave sequences undisturbed
// - Key compared least significant bit first
// - Eight 8-bit registers, one bit per cycle
// - Timekeeping values are BCD
// - Transfer runs register 0 bit 0 upward
// - Hours bit 7 high selects 12-hour mode
// - Hours bit 5: PM or tens of hours
// - Day bit 4 clear lets reset pin abort
// - Reset pin abort overrides key and transfer events; memory writes still land
// - Day bit 5 clear runs the timebase
// - Unused bits read zero, writes accepted
`timescale 1ns/1ps
`default_nettype none
module hidden_rtc #(
	parameter int          TICK_CYCLES = rtc_pkg::TICK_CYCLES,
	parameter logic [63:0] KEY         = rtc_pkg::KEY_DEFAULT
) (
	input  wire logic                      ref_clk,    // Clock
	input  wire logic                      reset,      // Async reset
	input  wire logic                      ce_n,       // Chip enable
	input  wire logic                      oe_n,       // Output enable
	input  wire logic                      we_n,       // Write enable
	input  wire logic [rtc_pkg::ADDR_W-1:0] addr,      // Address
	input  wire logic [7:0]                data_in,    // Data from bus
	input  wire logic                      power_fail, // Below threshold
	input  wire logic                      rst_pin_n,  // Abort pin
	output logic      [7:0]                data_out,   // Data to bus
	output logic                           data_oe_n   // Low: driving
);
	localparam int EW = 1 + rtc_pkg::ADDR_W + 8;

	// ====================================================
	// BCD helpers
	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (v == hi)
			return {1'b1, lo};
		else if (v[3:0] == 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [8:0] hour_inc(input logic [7:0] h);
		logic [7:0] r;
		logic       c;
		r = h;
		c = 1'b0;
		if (h[rtc_pkg::HR_MODE12])
		begin
			if (h[4:0] == 5'h12)
				r[4:0] = 5'h01;
			else if (h[4:0] == 5'h11)
			begin
				r[4:0] = 5'h12;
				r[rtc_pkg::HR_PM] = ~h[rtc_pkg::HR_PM];
				c = h[rtc_pkg::HR_PM];
			end
			else if (h[3:0] == 4'h9)
				r[4:0] = 5'h10;
			else
				r[3:0] = h[3:0] + 4'h1;
		end
		else
		begin
			if (h[5:0] == 6'h23)
			begin
				r[5:0] = 6'h00;
				c = 1'b1;
			end
			else if (h[3:0] == 4'h9)
				r[5:0] = {h[5:4] + 2'h1, 4'h0};
			else
				r[3:0] = h[3:0] + 4'h1;
		end
		return {c, r};
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02:   return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// ====================================================
	// State
	logic [31:0]          tick_cnt_reg, tick_cnt_next;
	logic                 tick_reg, tick_next;
	logic                 act_reg, act_next;
	logic                 wr_reg, wr_next;
	logic [rtc_pkg::ADDR_W-1:0] cad_reg, cad_next;
	logic [7:0]           cdat_reg, cdat_next;
	logic                 pend_reg, pend_next;
	logic [EW-1:0]        buf_reg [2];
	logic [EW-1:0]        buf_next [2];
	logic                 wp_reg, wp_next, rp_reg, rp_next;
	logic [1:0]           cnt_reg, cnt_next;
	rtc_pkg::mode_t       mode_reg, mode_next;
	logic [5:0]           ptr_reg, ptr_next;
	logic                 wrote_reg, wrote_next;
	logic [63:0]          time_reg, time_next;
	logic [63:0]          shadow_reg, shadow_next;
	logic [7:0]           dout_reg, dout_next;
	logic                 doe_n_reg, doe_n_next;
	logic [7:0]           mem [2**rtc_pkg::ADDR_W];
	logic [7:0]           mem_word_reg;

	logic                 bus_sel, push, pop, in_ready;
	logic                 ev_wr, ev_bit, mem_we, apply, rst_abort;
	logic [EW-1:0]        ev;
	logic                 reading;

	// ====================================================
	// Timebase divider
	always_comb
	begin
		tick_cnt_next = tick_cnt_reg + 32'h1;
		tick_next = 1'b0;
		if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
		begin
			tick_cnt_next = 32'h0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg <= tick_next;
		end

	// ====================================================
	// Bus cycle capture; deselected cycles make no event
	assign bus_sel = !power_fail && !ce_n && (!we_n || !oe_n);
	assign in_ready = (cnt_reg != 2'h2);
	assign push = pend_reg && in_ready;

	always_comb
	begin
		act_next = act_reg;
		wr_next = wr_reg;
		cad_next = cad_reg;
		cdat_next = cdat_reg;
		pend_next = pend_reg && !in_ready;
		if (!act_reg)
		begin
			if (bus_sel && !pend_reg)
			begin
				act_next = 1'b1;
				wr_next = !we_n;
				cad_next = addr;
				cdat_next = data_in;
			end
		end
		else if (power_fail)
			act_next = 1'b0;
		else if (!bus_sel)
		begin
			act_next = 1'b0;
			pend_next = 1'b1;
		end
		else if (!we_n)
		begin
			wr_next = 1'b1;
			cad_next = addr;
			cdat_next = data_in;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			act_reg <= 1'b0;
			wr_reg <= 1'b0;
			cad_reg <= '0;
			cdat_reg <= 8'h00;
			pend_reg <= 1'b0;
		end
		else
		begin
			act_reg <= act_next;
			wr_reg <= wr_next;
			cad_reg <= cad_next;
			cdat_reg <= cdat_next;
			pend_reg <= pend_next;
		end

	// ====================================================
	// Two-entry event buffer; drain stalls on timebase ticks
	// so counting and snapshot updates never collide
	assign pop = (cnt_reg != 2'h0) && !tick_reg;
	assign ev = buf_reg[rp_reg];
	assign ev_wr = ev[EW-1];
	assign ev_bit = ev[0];

	always_comb
	begin
		buf_next = buf_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		if (push)
		begin
			buf_next[wp_reg] = {wr_reg, cad_reg, cdat_reg};
			wp_next = !wp_reg;
		end
		if (pop)
			rp_next = !rp_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 2'h1;
		else if (pop && !push)
			cnt_next = cnt_reg - 2'h1;
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end
		else
		begin
			buf_reg <= buf_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end

	// ====================================================
	// Key search and serial transfer
	assign rst_abort = !rst_pin_n
		&& !time_reg[rtc_pkg::RSTGATE_BIT];

	always_comb
	begin
		mode_next = mode_reg;
		ptr_next = ptr_reg;
		wrote_next = wrote_reg;
		apply = 1'b0;
		if (rst_abort)
		begin
			mode_next = rtc_pkg::ST_MEMORY;
			ptr_next = 6'h00;
		end
		else if (pop)
		begin
			case (mode_reg)
				rtc_pkg::ST_MEMORY, rtc_pkg::ST_MATCH,
				rtc_pkg::ST_REJECT:
				begin
					if (!ev_wr)
					begin
						mode_next = rtc_pkg::ST_MATCH;
						ptr_next = 6'h00;
					end
					else if (mode_reg == rtc_pkg::ST_MATCH)
					begin
						if (ev_bit == KEY[ptr_reg])
						begin
							ptr_next = ptr_reg + 6'h1;
							if (ptr_reg == rtc_pkg::LAST_BIT)
							begin
								mode_next = rtc_pkg::ST_XFER;
								wrote_next = 1'b0;
							end
						end
						else
							mode_next = rtc_pkg::ST_REJECT;
					end
				end
				rtc_pkg::ST_XFER:
				begin
					if (ev_wr)
						wrote_next = 1'b1;
					ptr_next = ptr_reg + 6'h1;
					if (ptr_reg == rtc_pkg::LAST_BIT)
					begin
						mode_next = rtc_pkg::ST_MEMORY;
						apply = wrote_next;
					end
				end
				default: mode_next = rtc_pkg::ST_MEMORY;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			mode_reg <= rtc_pkg::ST_MEMORY;
			ptr_reg <= 6'h00;
			wrote_reg <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			ptr_reg <= ptr_next;
			wrote_reg <= wrote_next;
		end

	// ====================================================
	// Timekeeping registers, held in BCD
	always_comb
	begin
		logic [63:0] t;
		logic [8:0]  c;
		t = time_reg;
		c = 9'h000;
		shadow_next = shadow_reg;
		if (!rst_abort && pop && mode_reg == rtc_pkg::ST_MATCH
			&& ev_wr && ev_bit == KEY[ptr_reg]
			&& ptr_reg == rtc_pkg::LAST_BIT)
			shadow_next = time_reg;
		if (!rst_abort && pop && mode_reg == rtc_pkg::ST_XFER
			&& ev_wr)
			shadow_next[ptr_reg] = ev_bit;
		if (tick_reg && !time_reg[rtc_pkg::TIMEBASE_STOP_BIT])
		begin
			c = bcd_inc(t[rtc_pkg::HSEC_LSB +: 8], 8'h00, 8'h99);
			t[rtc_pkg::HSEC_LSB +: 8] = c[7:0];
			if (c[8])
			begin
				c = bcd_inc(t[rtc_pkg::SEC_LSB +: 8], 8'h00, 8'h59);
				t[rtc_pkg::SEC_LSB +: 8] = c[7:0];
			end
			if (c[8])
			begin
				c = bcd_inc(t[rtc_pkg::MIN_LSB +: 8], 8'h00, 8'h59);
				t[rtc_pkg::MIN_LSB +: 8] = c[7:0];
			end
			if (c[8])
			begin
				c = hour_inc(t[rtc_pkg::HOUR_LSB +: 8]);
				t[rtc_pkg::HOUR_LSB +: 8] = c[7:0];
			end
			if (c[8])
			begin
				t[rtc_pkg::DAY_LSB +: 3] =
					(t[rtc_pkg::DAY_LSB +: 3] == 3'h7) ? 3'h1
					: t[rtc_pkg::DAY_LSB +: 3] + 3'h1;
				c = bcd_inc(t[rtc_pkg::DATE_LSB +: 8], 8'h01,
					month_len(t[rtc_pkg::MON_LSB +: 8],
						t[rtc_pkg::YEAR_LSB +: 8]));
				t[rtc_pkg::DATE_LSB +: 8] = c[7:0];
			end
			if (c[8])
			begin
				c = bcd_inc(t[rtc_pkg::MON_LSB +: 8], 8'h01, 8'h12);
				t[rtc_pkg::MON_LSB +: 8] = c[7:0];
			end
			if (c[8])
			begin
				c = bcd_inc(t[rtc_pkg::YEAR_LSB +: 8], 8'h00, 8'h99);
				t[rtc_pkg::YEAR_LSB +: 8] = c[7:0];
			end
		end
		// Unused positions stay zero whatever was written; the last
		// serial bit lands in this same cycle, so apply the next snapshot
		time_next = apply ? (shadow_next & rtc_pkg::WRITE_MASK)
			: (t & rtc_pkg::WRITE_MASK);
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			time_reg <= rtc_pkg::TIME_RESET;
			shadow_reg <= rtc_pkg::TIME_RESET;
		end
		else
		begin
			time_reg <= time_next;
			shadow_reg <= shadow_next;
		end

	// ====================================================
	// Memory array; unlocked cycles never touch it
	assign mem_we = pop && ev_wr
		&& mode_reg != rtc_pkg::ST_XFER;

	always_ff @(posedge ref_clk)
	begin
		if (mem_we)
			mem[ev[EW-2:8]] <= ev[7:0];
		mem_word_reg <= mem[addr];
	end

	// ====================================================
	// Bus read data
	assign reading = !power_fail && !ce_n && !oe_n && we_n;

	always_comb
	begin
		doe_n_next = !reading;
		dout_next = mem_word_reg;
		if (mode_reg == rtc_pkg::ST_XFER)
			dout_next = {7'h00, shadow_reg[ptr_reg]};
	end

	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			dout_reg <= 8'h00;
			doe_n_reg <= 1'b1;
		end
		else
		begin
			dout_reg <= dout_next;
			doe_n_reg <= doe_n_next;
		end

	assign data_out = dout_reg;
	assign data_oe_n = doe_n_reg;

	// ====================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	pfail_no_drive_a: assert property (
		power_fail |=> data_oe_n)
		else $error("bus driven during power fail");

	pfail_no_event_a: assert property (
		$rose(pend_reg) |-> !$past(power_fail))
		else $error("cycle taken during power fail");

	key_match_a: assert property (
		!rst_abort && pop && mode_reg == rtc_pkg::ST_MATCH && ev_wr
		&& ev_bit == KEY[ptr_reg] && ptr_reg == rtc_pkg::LAST_BIT
		|=> mode_reg == rtc_pkg::ST_XFER && ptr_reg == 6'h00)
		else $error("full key did not unlock");

	key_miss_a: assert property (
		!rst_abort && pop && mode_reg == rtc_pkg::ST_MATCH && ev_wr
		&& ev_bit != KEY[ptr_reg]
		|=> mode_reg == rtc_pkg::ST_REJECT && $stable(ptr_reg))
		else $error("mismatch not latched");

	read_restart_a: assert property (
		!rst_abort && pop && !ev_wr && mode_reg != rtc_pkg::ST_XFER
		|=> mode_reg == rtc_pkg::ST_MATCH && ptr_reg == 6'h00)
		else $error("read did not restart search");

	xfer_bit_a: assert property (
		!rst_abort && pop && ev_wr && mode_reg == rtc_pkg::ST_XFER
		|=> shadow_reg[$past(ptr_reg)] == $past(ev_bit))
		else $error("serial bit not stored");

	xfer_mem_off_a: assert property (
		mode_reg == rtc_pkg::ST_XFER |=> data_out[7:1] == 7'h00)
		else $error("memory shown while unlocked");

	pin_abort_a: assert property (
		rst_abort |=> mode_reg == rtc_pkg::ST_MEMORY
		&& shadow_reg == $past(shadow_reg))
		else $error("reset pin abort failed");

	zero_bits_a: assert property (
		(time_reg & ~rtc_pkg::WRITE_MASK) == 64'h0)
		else $error("unused bit set");

	end_apply_a: assert property (
		!rst_abort && pop && mode_reg == rtc_pkg::ST_XFER
		&& ptr_reg == rtc_pkg::LAST_BIT && (wrote_reg || ev_wr)
		|=> mode_reg == rtc_pkg::ST_MEMORY
		&& time_reg == (shadow_reg & rtc_pkg::WRITE_MASK))
		else $error("snapshot not applied");
endmodule
`default_nettype wire

// ---- logic/rtc_pkg.sv ----
// Constants and types shared by the hidden real-time clock
`default_nettype none
package rtc_pkg;
	// ====================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TICK_PERIOD_NS = 10_000_000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// ====================================================
	// Bus and serial sequence
	localparam int ADDR_W    = 17;
	localparam int KEY_BITS  = 64;
	localparam int XFER_BITS = 64;
	localparam logic [5:0] LAST_BIT = 6'h3f;
	// Arbitrary default, replaced by the integrator
	localparam logic [63:0] KEY_DEFAULT = 64'h0123_4567_89ab_cdef;
	// ====================================================
	// Timekeeping layout, register 0 in the low byte
	localparam int HSEC_LSB = 0;
	localparam int SEC_LSB  = 8;
	localparam int MIN_LSB  = 16;
	localparam int HOUR_LSB = 24;
	localparam int DAY_LSB  = 32;
	localparam int DATE_LSB = 40;
	localparam int MON_LSB  = 48;
	localparam int YEAR_LSB = 56;
	localparam int HR_MODE12 = 7;
	localparam int HR_PM     = 5;
	localparam int RSTGATE_BIT = 36;
	localparam int TIMEBASE_STOP_BIT = 37;
	localparam logic [63:0] TIME_RESET = 64'h0001_0101_0000_0000;
	localparam logic [63:0] WRITE_MASK = 64'hff1f_3f37_bf7f_7fff;
	// ====================================================
	// Serial access state
	typedef enum logic [1:0] {
		ST_MEMORY = 2'b00,
		ST_MATCH  = 2'b01,
		ST_REJECT = 2'b10,
		ST_XFER   = 2'b11
	} mode_t;
endpackage
`default_nettype wire

// ---- testbench/sram_host.sv ----
// Host bus master model driving the SRAM-style bus
`timescale 1ns/1ps
`default_nettype none
module sram_host (
	input  wire logic                       ref_clk,   // Clock
	output logic                            ce_n,      // Chip enable
	output logic                            oe_n,      // Output enable
	output logic                            we_n,      // Write enable
	output logic [rtc_pkg::ADDR_W-1:0]      addr,      // Address
	output logic [7:0]                      data_in,   // Data to device
	input  wire logic [7:0]                 data_out,  // Data from device
	input  wire logic                       data_oe_n  // Low: device drives
);
	// ====================================================
	// Bus cycle
	// Four-edge low phase and three-edge gap meet the minimum;
	// data is taken at the falling edge, once the outputs have settled
	task automatic cyc(
		input  logic                       wr,
		input  logic                       sel,
		input  logic [rtc_pkg::ADDR_W-1:0] a,
		input  logic [7:0]                 d,
		output logic [7:0]                 q,
		output logic                       oe
	);
		@(negedge ref_clk);
		ce_n = !sel;
		oe_n = wr;
		we_n = !wr;
		addr = a;
		data_in = wr ? d : ~data_in;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		q = data_out;
		oe = data_oe_n;
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		// A released bus must not keep showing the last byte
		data_in = ~data_in;
		repeat (3) @(posedge ref_clk);
	endtask

	initial
	begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		addr = '0;
		data_in = 8'h00;
	end
endmodule
`default_nettype wire

// ---- testbench/hidden_rtc_test.sv ----
// Self-checking bench for the hidden real-time clock
`timescale 1ns/1ps
`default_nettype none
module hidden_rtc_test;
	localparam logic [16:0] SCR = 17'h00100;
	localparam logic [16:0] MEM = 17'h00300;
	localparam logic [63:0] KEY = rtc_pkg::KEY_DEFAULT;
	localparam logic [63:0] T1  = 64'h8912_3135_2359_5800;
	localparam logic [63:0] T2  = 64'h2312_3105_b259_0000;
	localparam logic [63:0] T3  = 64'h2312_3105_2359_5990;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        power_fail = 1'b0;
	logic        rst_pin_n = 1'b1;
	logic        ce_n;
	logic        oe_n;
	logic        we_n;
	logic [16:0] addr;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic        data_oe_n;
	logic [7:0]  q;
	logic        oe;
	logic [63:0] v;
	int          err_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	// ====================================================
	// Device and host
	hidden_rtc #(.TICK_CYCLES(20)) DUT (
		.ref_clk(ref_clk), .reset(reset), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .data_in(data_in),
		.power_fail(power_fail), .rst_pin_n(rst_pin_n),
		.data_out(data_out), .data_oe_n(data_oe_n));
	sram_host host (
		.ref_clk(ref_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n));

	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end

	// ====================================================
	// Tasks
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("Errors %0d of %0d compares", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic rd(input logic [16:0] a);
		host.cyc(1'b0, 1'b1, a, 8'h00, q, oe);
	endtask

	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		host.cyc(1'b1, 1'b1, a, d, q, oe);
	endtask

	// A cycle for another device on the bus, never selected
	task automatic foreign();
		host.cyc(1'b0, 1'b0, 17'h00001, 8'h00, q, oe);
	endtask

	// Key sequence; bad names one bit sent inverted, -1 for none
	task automatic unlock(input int bad);
		rd(SCR);
		for (int i = 0; i < 64; i++)
		begin
			if (i == 20)
				foreign();
			wr(SCR, {7'h55, KEY[i] ^ (i == bad)});
		end
	endtask

	// 64 serial cycles; reset pin pulsed before cycle p
	task automatic xfer(input logic w_en, input logic [63:0] w,
		input int p, output logic [63:0] r);
		logic hi;
		hi = 1'b0;
		for (int i = 0; i < 64; i++)
		begin
			if (i == p)
			begin
				@(negedge ref_clk);
				rst_pin_n = 1'b0;
				repeat (5) @(negedge ref_clk);
				rst_pin_n = 1'b1;
			end
			if (i == 30)
				foreign();
			host.cyc(w_en, 1'b1, SCR, {7'h7f, w[i]}, q, oe);
			r[i] = q[0];
			hi = hi | (|q[7:1]) | (oe & !w_en);
		end
		if (!w_en)
			check(hi, 1'b0);
	endtask

	// ====================================================
	// Sequence
	initial
	begin
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		wr(MEM, 8'ha5);
		rd(MEM);
		check(q, 8'ha5);
		check(oe, 1'b0);
		// Unused bits written as ones must read back clear
		unlock(-1);
		xfer(1'b1, T1 | ~rtc_pkg::WRITE_MASK, -1, v);
		rd(SCR);
		check(q, {7'h55, KEY[63]});
		// Reset gate set: the pin pulse is ignored
		unlock(-1);
		xfer(1'b0, 64'h0, 10, v);
		check(v, T1);
		// Partial key then a read restarts the search
		rd(SCR);
		for (int i = 0; i < 10; i++)
			wr(SCR, {7'h55, KEY[i]});
		unlock(-1);
		xfer(1'b1, T2, -1, v);
		unlock(-1);
		xfer(1'b0, 64'h0, -1, v);
		check(v[63:16], T2[63:16]);
		check(v[7:0] != 8'h00, 1'b1);
		// Reset gate clear: pin aborts a write transfer
		unlock(-1);
		xfer(1'b1, 64'h0, 10, v);
		wr(MEM, 8'hc3);
		rd(MEM);
		check(q, 8'hc3);
		unlock(-1);
		xfer(1'b0, 64'h0, -1, v);
		check(v[63:16], T2[63:16]);
		// Midnight in 24-hour mode carries into day, date, month, year
		unlock(-1);
		xfer(1'b1, T3, -1, v);
		unlock(-1);
		xfer(1'b0, 64'h0, -1, v);
		check(v[63:8], 56'h2401_0106_0000_00);
		// One wrong key bit leaves the bus in memory mode
		unlock(5);
		wr(MEM, 8'h3c);
		rd(MEM);
		check(q, 8'h3c);
		@(negedge ref_clk);
		power_fail = 1'b1;
		wr(MEM, 8'h99);
		rd(MEM);
		check(oe, 1'b1);
		@(negedge ref_clk);
		power_fail = 1'b0;
		rd(MEM);
		check(q, 8'h3c);
		test_done();
	end

	// Run takes about 8000 cycles; the ceiling leaves a wide margin
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_count++;
			test_done();
		end
	end
endmodule
`default_nettype wire
